// ### bench/bspc_front_model.sv
// front-panel model: keys, knob and remote requests as the operator presents them
`timescale 1ns/1ps

module bspc_front_model (
  // operator actions, changed by the bench just after the clock edge
  input  wire logic [6:0]   tap_i,
  input  wire logic [2:0]   held_i,
  input  wire logic [15:0]  rate_i,
  input  wire logic         rate_valid_i,
  // key presses and knob detents, one-cycle pulses
  output logic              output_key_o,
  output logic              range_key_o,
  output logic              step_key_o,
  output logic              local_key_o,
  output logic              knob_cw_o,
  output logic              knob_ccw_o,
  output logic              remote_req_o,
  // held key levels
  output logic              step_held_o,
  output logic              local_held_o,
  output logic              shift_held_o,
  // serial rate requests
  output logic [15:0]       baud_req_o,
  output logic              baud_valid_o
);
  assign {remote_req_o, knob_ccw_o, knob_cw_o, local_key_o, step_key_o, range_key_o, output_key_o} = tap_i;
  // levels are {step, local, shift}
  assign {step_held_o, local_held_o, shift_held_o} = held_i;
  // an idle rate line shows the complement, so stale data never looks like a valid request
  assign baud_req_o   = rate_valid_i ? rate_i : ~rate_i;
  assign baud_valid_o = rate_valid_i;
endmodule : bspc_front_model

// ### bench/testbench.sv
// self-checking bench for the panel control block
`timescale 1ns/1ps

module testbench;
  import bspc_pkg::*;
  typedef struct {logic [4:0] id; logic [19:0] v;} bspc_note_t;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [2:0] over_range = 3'h0;
  logic [19:0] m1 = 20'h0, m2 = 20'h0, m3 = 20'h0;
  logic ok, rk, sk, lk, cw, ccw, rr, sh, lh, hh, bv;
  logic [15:0] br;
  logic [6:0]  tap    = 7'h00;
  logic [2:0]  held   = 3'h4; // step key down at power-up asks for factory values
  logic [15:0] rate   = 16'h0000;
  logic        rate_v = 1'b0;
  logic en, ol, dash, trip, rlamp, fast, flamp, klamp, remlamp, octrip, sre, ack, fol;
  logic [1:0] sel, r1, r2, r3, tch;
  logic [15:0] s1, s2, s3, dv, baud;
  logic [19:0] da;
  logic [4:0] addr;
  bspc_note_t notes[$];
  bspc_note_t n;
  int err_count = 0;
  int samples_checked = 0;
  int i;
  logic b;

  initial forever #25 ref_clk_i = ~ref_clk_i;

  bspc_front_model bspc_front_model_inst (.tap_i(tap), .held_i(held), .rate_i(rate), .rate_valid_i(rate_v),
    .output_key_o(ok), .range_key_o(rk),
    .step_key_o(sk), .local_key_o(lk), .knob_cw_o(cw), .knob_ccw_o(ccw), .remote_req_o(rr),
    .step_held_o(sh), .local_held_o(lh), .shift_held_o(hh), .baud_req_o(br), .baud_valid_o(bv));

  bspc_panel #(.TRIP_CNT(50), .UNLOCK_CNT(20), .TICK_CNT(10)) bspc_panel_inst (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .output_key_i(ok), .range_key_i(rk),
    .channel_step_key_i(sk), .channel_step_held_i(sh), .local_key_i(lk), .local_held_i(lh),
    .shift_held_i(hh), .knob_cw_i(cw), .knob_ccw_i(ccw), .remote_req_i(rr), .baud_req_i(br),
    .baud_req_valid_i(bv), .over_range_i(over_range), .meter_ch1_i(m1), .meter_ch2_i(m2),
    .meter_ch3_i(m3), .output_en_o(en), .setpoint_ch1_o(s1), .setpoint_ch2_o(s2),
    .setpoint_ch3_o(s3), .range_ch1_o(r1), .range_ch2_o(r2), .range_ch3_o(r3), .fast_sample_o(fast),
    .sel_chan_o(sel), .disp_volt_o(dv), .disp_amp_o(da), .disp_dash_o(dash), .disp_trip_o(trip),
    .disp_trip_chan_o(tch), .output_lamp_o(ol), .range_lamp_o(rlamp), .fast_lamp_o(flamp),
    .lock_lamp_o(klamp), .remote_lamp_o(remlamp), .overcurrent_trip_o(octrip), .sre_o(sre),
    .ack_msg_o(ack), .auto_channel_follow_o(fol), .bus_addr_o(addr), .baud_o(baud));

  function automatic logic [19:0] seen(input logic [4:0] id);
    case (id)
      5'h00: seen = {19'h0, en};
      5'h01: seen = {19'h0, ol};
      5'h02: seen = {18'h0, sel};
      5'h03: seen = {4'h0, dv};
      5'h04: seen = da;
      5'h05: seen = {19'h0, dash};
      5'h06: seen = {18'h0, trip, octrip};
      5'h07: seen = {18'h0, tch};
      5'h08: seen = {17'h0, r1, rlamp};
      5'h0A: seen = {16'h0, r3, r2};
      5'h0B: seen = {18'h0, fast, flamp};
      5'h0C: seen = {19'h0, klamp};
      5'h0D: seen = {19'h0, remlamp};
      5'h0E: seen = {4'h0, s1};
      5'h0F: seen = {4'h0, baud};
      5'h10: seen = {12'h0, addr, sre, ack, fol};
      default: seen = {4'h0, s2 | s3};
    endcase
  endfunction : seen

  task automatic chk(input logic [19:0] s, input logic [19:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic note(input logic [4:0] id, input logic [19:0] v);
    notes.push_back('{id, v});
  endtask : note

  task automatic press(input int k);
    @(posedge ref_clk_i);
    tap <= 7'(1 << k);
    @(posedge ref_clk_i);
    tap <= 7'h00;
    repeat (3) @(posedge ref_clk_i);
  endtask : press

  // levels are {step, local, shift}
  task automatic hold(input logic [2:0] lvl);
    @(posedge ref_clk_i);
    held <= lvl;
  endtask : hold

  task automatic set_rate(input logic [15:0] v);
    @(posedge ref_clk_i);
    rate   <= v;
    rate_v <= 1'b1;
    @(posedge ref_clk_i);
    rate   <= ~v;
    rate_v <= 1'b0;
  endtask : set_rate

  task automatic turn(input int k, input int gap, input logic [15:0] v);
    repeat (gap) @(posedge ref_clk_i);
    press(k);
    note(5'h0E, {4'h0, v});
    note(5'h03, {4'h0, v});
  endtask : turn

  task automatic test_done;
    // let the watcher drain the last notes first
    repeat (2) @(negedge ref_clk_i);
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // result watcher
  // ----------------------------------------------------------------
  always @(negedge ref_clk_i) begin
    while (notes.size() > 0) begin
      n = notes.pop_front();
      chk(seen(n.id), n.v);
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(97792));
    repeat (6) @(posedge ref_clk_i);
    m1 <= 20'($urandom);
    m2 <= 20'($urandom);
    m3 <= 20'($urandom);
    sys_rst_i <= 1'b0;
    hold(3'h0);
    repeat (3) @(posedge ref_clk_i);
    note(5'h00, 0);
    note(5'h0D, 0);
    note(5'h06, 0);
    note(5'h10, 20'h0B);
    note(5'h02, 0);
    note(5'h0E, 0);
    note(5'h08, 3);
    note(5'h0B, 0);
    note(5'h0C, 0);
    note(5'h0F, 20'h04B00);
    for (int c = 1; c <= 3; c++) begin
      press(2);
      note(5'h02, 20'(c % 3));
      note(5'h04, (c % 3 == 0 ? m1 : c == 1 ? m2 : m3) & 20'hFFFF0);
      note(5'h03, 0);
    end
    // slow gaps give single steps, quick ones large steps
    turn(4, 1300, 16'h0001);
    turn(4, 20, 16'h0065);
    turn(4, 500, 16'h006F);
    turn(5, 1300, 16'h006E);
    press(1);
    note(5'h08, 0);
    press(1);
    note(5'h08, 3);
    press(2);
    press(1);
    note(5'h08, 3);
    note(5'h0A, 20'hA);
    note(5'h11, 0);
    press(2);
    press(2);
    hold(3'h1);
    press(2);
    note(5'h0B, 3);
    note(5'h02, 0);
    note(5'h04, m1);
    press(2);
    note(5'h0B, 0);
    press(3);
    hold(3'h0);
    note(5'h0C, 1);
    press(1);
    note(5'h08, 3);
    press(0);
    note(5'h00, 1);
    note(5'h01, 1);
    press(0);
    note(5'h00, 0);
    hold(3'h3);
    repeat (10) @(posedge ref_clk_i);
    hold(3'h0);
    repeat (3) @(posedge ref_clk_i);
    note(5'h0C, 1);
    hold(3'h3);
    repeat (30) @(posedge ref_clk_i);
    hold(3'h0);
    repeat (3) @(posedge ref_clk_i);
    note(5'h0C, 0);
    press(6);
    note(5'h0D, 1);
    press(1);
    note(5'h08, 3);
    press(3);
    note(5'h0D, 0);
    note(5'h0C, 0);
    press(0);
    over_range <= 3'h1;
    repeat (4) @(posedge ref_clk_i);
    note(5'h05, 1);
    repeat (26) @(posedge ref_clk_i);
    over_range <= 3'h0;
    repeat (4) @(posedge ref_clk_i);
    note(5'h06, 0);
    note(5'h00, 1);
    note(5'h05, 0);
    over_range <= 3'h1;
    repeat (60) @(posedge ref_clk_i);
    note(5'h06, 3);
    note(5'h00, 0);
    note(5'h07, 0);
    // lamp is looked at between edges, where it has settled
    repeat (2) begin
      @(negedge ref_clk_i);
      b = ol;
      for (i = 0; i < 6000 && ol === b; i++) @(negedge ref_clk_i);
      chk({19'h0, ol !== b}, 1);
      if (i >= 6000) test_done();
    end
    @(posedge ref_clk_i);
    over_range <= 3'h0;
    press(0);
    note(5'h06, 0);
    note(5'h00, 0);
    set_rate(16'h9600);
    repeat (3) @(posedge ref_clk_i);
    note(5'h0F, 20'h09600);
    set_rate(16'h9601);
    repeat (3) @(posedge ref_clk_i);
    note(5'h0F, 20'h09600);
    test_done();
  end
endmodule : testbench

// ### core/bspc_panel.sv
// front-panel control logic of a three-channel precision source
// Notes on behaviour
// [RULE1] output key flips output enable; lamp steady while enabled
// [RULE2] lamp blinks while overcurrent trip holds output off
// [RULE3] trip fires only after over-range persists 1.5 s
// [RULE4] meter shows dashes while selected channel is over-range
// [RULE5] meter and voltage display follow the selected channel
// [RULE6] range key toggles channel-1 range and lamp; on means 200 mA
// [RULE7] range key ignored unless channel 1; others fixed at 30 mA
// [RULE8] channel step key selects channel for knob and meter
// [RULE9] channel step advances 1, 2, 3, back to 1
// [RULE10] clockwise raises setpoint, counterclockwise lowers it
// [RULE11] faster knob turning gives larger steps per detent
// [RULE12] local key while remote leaves remote control
// [RULE13] shift plus channel step toggles fast sampling and lamp
// [RULE14] fast sampling presents five-digit meter resolution
// [RULE15] shift plus local engages key lock; only output key works
// [RULE16] lock releases only after shift plus local held 0.5 s
// [RULE17] power-on: output off, local, trip clear, sre 0, ack, follow
// [RULE18] retained settings keep values; factory defaults defined
// [RULE19] channel step held at power-on restores factory values
// [RULE20] serial port supports rates up to 38400 bps
// [RULE21] trip disables output and shows offending channel
// [RULE22] output key press during trip clears the trip
`timescale 1ns/1ps

module bspc_panel
  import bspc_pkg::*;
#(
  parameter int unsigned TRIP_CNT   = TRIP_CYCLES,
  parameter int unsigned UNLOCK_CNT = UNLOCK_CYCLES,
  parameter int unsigned TICK_CNT   = TICK_CYCLES
) (
  // clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         sys_rst_i,
  // keys, one-cycle press pulses except held levels
  input  wire logic         output_key_i,
  input  wire logic         range_key_i,
  input  wire logic         channel_step_key_i,
  input  wire logic         channel_step_held_i,
  input  wire logic         local_key_i,
  input  wire logic         local_held_i,
  input  wire logic         shift_held_i,
  // knob detent pulses
  input  wire logic         knob_cw_i,
  input  wire logic         knob_ccw_i,
  // remote side
  input  wire logic         remote_req_i,
  input  wire logic [15:0]  baud_req_i,
  input  wire logic         baud_req_valid_i,
  // channel meters
  input  wire logic [2:0]   over_range_i,
  input  wire logic [19:0]  meter_ch1_i,
  input  wire logic [19:0]  meter_ch2_i,
  input  wire logic [19:0]  meter_ch3_i,
  // regulator controls
  output logic              output_en_o,
  output logic [15:0]       setpoint_ch1_o,
  output logic [15:0]       setpoint_ch2_o,
  output logic [15:0]       setpoint_ch3_o,
  output logic [1:0]        range_ch1_o,
  output logic [1:0]        range_ch2_o,
  output logic [1:0]        range_ch3_o,
  output logic              fast_sample_o,
  // display and lamps
  output logic [1:0]        sel_chan_o,
  output logic [15:0]       disp_volt_o,
  output logic [19:0]       disp_amp_o,
  output logic              disp_dash_o,
  output logic              disp_trip_o,
  output logic [1:0]        disp_trip_chan_o,
  output logic              output_lamp_o,
  output logic              range_lamp_o,
  output logic              fast_lamp_o,
  output logic              lock_lamp_o,
  output logic              remote_lamp_o,
  // non-retained and retained misc state
  output logic              overcurrent_trip_o,
  output logic              sre_o,
  output logic              ack_msg_o,
  output logic              auto_channel_follow_o,
  output logic [4:0]        bus_addr_o,
  output logic [15:0]       baud_o
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [15:0] step_set(input logic [15:0] v, input logic up, input logic [15:0] st);
    logic [16:0] s;
    s = 17'h00000;
    if (up) begin
      s = {1'b0, v} + {1'b0, st};
      step_set = (s > {1'b0, SET_MAX}) ? SET_MAX : s[15:0];
    end else begin
      step_set = (v > st) ? (v - st) : 16'h0000;
    end
  endfunction : step_set

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bspc_chan_t  sel_reg;
  logic [15:0] set_reg [3];
  logic        rng200_reg;
  logic        fast_reg;
  logic        lock_reg;
  logic        out_reg;
  logic        trip_reg;
  logic [1:0]  trip_chan_reg;
  logic        remote_reg;
  logic        init_done_reg;
  logic [31:0] trip_cnt_reg;
  logic [31:0] unlock_cnt_reg;
  logic [31:0] tick_cnt_reg;
  logic        tick;
  logic [15:0] gap_reg;
  logic [7:0]  blink_cnt_reg;
  logic        blink_reg;
  logic        sel_over;
  logic        trip_fire;
  logic        keys_ok;
  logic        knob_ev;
  logic [15:0] knob_step;

  assign keys_ok   = init_done_reg && !lock_reg && !remote_reg;
  assign sel_over  = over_range_i[sel_reg];
  assign trip_fire = out_reg && !trip_reg && (trip_cnt_reg == TRIP_CNT - 1);
  assign knob_ev   = keys_ok && (knob_cw_i ^ knob_ccw_i);

  // ----------------------------------------------------------------
  // power-on strap: factory restore taken at every edge in reset and at the first edge after release
  // ----------------------------------------------------------------
  // retained storage is modelled by these flops; reset only applies factory values
  // when the strap asks for it, otherwise the previous contents stand
  logic restore;
  assign restore = !init_done_reg && channel_step_held_i; // RULE19

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      init_done_reg <= 1'b0;
    end else begin
      init_done_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // millisecond tick and knob speed
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_cnt_reg <= 32'h00000000;
    end else if (tick_cnt_reg == TICK_CNT - 1) begin
      tick_cnt_reg <= 32'h00000000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
    end
  end
  assign tick = (tick_cnt_reg == TICK_CNT - 1);

  // short gap between detents means fast turning
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gap_reg <= 16'hFFFF;
    end else if (knob_ev) begin
      gap_reg <= 16'h0000;
    end else if (tick && gap_reg != 16'hFFFF) begin
      gap_reg <= gap_reg + 16'h0001;
    end
  end

  always_comb begin
    if (gap_reg < 16'(FAST_GAP_TICKS)) begin
      knob_step = STEP_FAST; // RULE11
    end else if (gap_reg < 16'(MED_GAP_TICKS)) begin
      knob_step = STEP_MED;
    end else begin
      knob_step = STEP_SLOW;
    end
  end

  // ----------------------------------------------------------------
  // retained settings
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (restore) begin
      sel_reg    <= BSPC_CH1; // RULE18
      rng200_reg <= 1'b1;
      fast_reg   <= 1'b0;
      bus_addr_o <= ADDR_FACTORY;
      baud_o     <= BAUD_FACTORY;
      for (int i = 0; i < 3; i++) begin
        set_reg[i] <= SET_FACTORY;
      end
    end else if (keys_ok) begin
      if (channel_step_key_i && shift_held_i) begin
        fast_reg <= !fast_reg; // RULE13
      end else if (channel_step_key_i) begin
        case (sel_reg) // RULE8 RULE9
          BSPC_CH1: sel_reg <= BSPC_CH2;
          BSPC_CH2: sel_reg <= BSPC_CH3;
          default:  sel_reg <= BSPC_CH1;
        endcase
      end
      if (range_key_i && sel_reg == BSPC_CH1) begin
        rng200_reg <= !rng200_reg; // RULE6 RULE7
      end
      if (knob_ev) begin
        set_reg[sel_reg] <= step_set(set_reg[sel_reg], knob_cw_i, knob_step); // RULE10
      end
    end
    if (!restore && baud_req_valid_i && baud_req_i != 16'h0000 && baud_req_i <= BAUD_MAX) begin
      baud_o <= baud_req_i; // RULE20
    end
  end

  // key lock is retained too, kept apart for its hold timer
  always_ff @(posedge ref_clk_i) begin
    if (restore) begin
      lock_reg       <= 1'b0;
      unlock_cnt_reg <= 32'h00000000;
    end else if (!lock_reg) begin
      unlock_cnt_reg <= 32'h00000000;
      if (init_done_reg && !remote_reg && shift_held_i && local_key_i) begin
        lock_reg <= 1'b1; // RULE15
      end
    end else if (shift_held_i && local_held_i) begin
      if (unlock_cnt_reg == UNLOCK_CNT - 1) begin
        lock_reg <= 1'b0; // RULE16
      end else begin
        unlock_cnt_reg <= unlock_cnt_reg + 32'h00000001;
      end
    end else begin
      unlock_cnt_reg <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // output, trip and remote (non-retained)
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      trip_cnt_reg <= 32'h00000000;
    end else if (out_reg && sel_over && !trip_reg) begin
      trip_cnt_reg <= trip_cnt_reg + 32'h00000001; // RULE3
    end else begin
      trip_cnt_reg <= 32'h00000000;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_reg       <= 1'b0; // RULE17
      trip_reg      <= 1'b0;
      trip_chan_reg <= 2'h0;
    end else if (trip_fire) begin
      out_reg       <= 1'b0; // RULE21
      trip_reg      <= 1'b1;
      trip_chan_reg <= sel_reg;
    end else if (init_done_reg && output_key_i && !remote_reg) begin
      if (trip_reg) begin
        trip_reg <= 1'b0; // RULE22
      end else begin
        out_reg <= !out_reg; // RULE1
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      remote_reg <= 1'b0;
    end else if (remote_reg && local_key_i && !shift_held_i) begin
      remote_reg <= 1'b0; // RULE12
    end else if (remote_req_i) begin
      remote_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      blink_cnt_reg <= 8'h00;
      blink_reg     <= 1'b0;
    end else if (tick) begin
      if (blink_cnt_reg == 8'(BLINK_TICKS - 1)) begin
        blink_cnt_reg <= 8'h00;
        blink_reg     <= !blink_reg;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      output_en_o           <= 1'b0;
      output_lamp_o         <= 1'b0;
      overcurrent_trip_o    <= 1'b0;
      disp_trip_o           <= 1'b0;
      disp_trip_chan_o      <= 2'h0;
      remote_lamp_o         <= 1'b0;
      sre_o                 <= SRE_RESET; // RULE17
      ack_msg_o             <= 1'b1;
      auto_channel_follow_o <= 1'b1;
    end else begin
      output_en_o           <= out_reg && !trip_fire;
      output_lamp_o         <= trip_reg ? blink_reg : out_reg; // RULE1 RULE2
      overcurrent_trip_o    <= trip_reg;
      disp_trip_o           <= trip_reg; // RULE21
      disp_trip_chan_o      <= trip_chan_reg;
      remote_lamp_o         <= remote_reg;
      sre_o                 <= SRE_RESET;
      ack_msg_o             <= 1'b1;
      auto_channel_follow_o <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    sel_chan_o     <= sel_reg;
    setpoint_ch1_o <= set_reg[0];
    setpoint_ch2_o <= set_reg[1];
    setpoint_ch3_o <= set_reg[2];
    range_ch1_o    <= rng200_reg ? BSPC_RNG_200MA : BSPC_RNG_10MA;
    range_ch2_o    <= BSPC_RNG_30MA; // RULE7
    range_ch3_o    <= BSPC_RNG_30MA;
    range_lamp_o   <= rng200_reg; // RULE6
    fast_sample_o  <= fast_reg;
    fast_lamp_o    <= fast_reg; // RULE13
    lock_lamp_o    <= lock_reg; // RULE15
    disp_volt_o    <= set_reg[sel_reg]; // RULE5
    disp_dash_o    <= sel_over || !init_done_reg; // RULE4
    case (sel_reg) // RULE5
      BSPC_CH1: disp_amp_o <= fast_reg ? meter_ch1_i : {meter_ch1_i[19:4], 4'h0}; // RULE14
      BSPC_CH2: disp_amp_o <= fast_reg ? meter_ch2_i : {meter_ch2_i[19:4], 4'h0};
      default:  disp_amp_o <= fast_reg ? meter_ch3_i : {meter_ch3_i[19:4], 4'h0};
    endcase
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_trip_lamp_blink: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE2
    trip_reg && $changed(blink_reg) |=> output_lamp_o == blink_reg)
    else $error("lamp does not blink during trip");
  a_trip_off_out: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE21
    trip_fire |=> !out_reg && trip_reg ##1 !output_en_o && disp_trip_o)
    else $error("trip did not cut output");
  a_trip_needs_time: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE3
    $rose(trip_reg) |-> $past(trip_cnt_reg) == TRIP_CNT - 1)
    else $error("trip fired early");
  a_trip_clear_key: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE22
    trip_reg && output_key_i && !remote_reg && init_done_reg |=> !trip_reg)
    else $error("output key did not clear trip");
  a_range_ignored: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE7
    init_done_reg && !restore && sel_reg != BSPC_CH1 |=> $stable(rng200_reg))
    else $error("range changed off channel 1");
  a_lock_blocks_sel: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE15
    lock_reg && !restore |=> $stable(sel_reg))
    else $error("locked panel changed channel");
  a_unlock_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE16
    $fell(lock_reg) && $past(init_done_reg) |-> $past(unlock_cnt_reg) == UNLOCK_CNT - 1)
    else $error("lock released early");
  a_out_toggle: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE1
    init_done_reg && output_key_i && !remote_reg && !trip_reg && !trip_fire |=> out_reg != $past(out_reg))
    else $error("output key did not toggle");
  a_step_cycle: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE9
    keys_ok && !restore && channel_step_key_i && !shift_held_i && sel_reg == BSPC_CH3 |=> sel_reg == BSPC_CH1)
    else $error("channel step did not wrap");

endmodule : bspc_panel

// ### core/bspc_pkg.sv
// constants and types for the bench source panel control block
package bspc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned TRIP_TIME_MS    = 1500;
  localparam int unsigned UNLOCK_TIME_MS  = 500;
  localparam int unsigned TRIP_CYCLES     = (CLK_HZ / 1000) * TRIP_TIME_MS;
  localparam int unsigned UNLOCK_CYCLES   = (CLK_HZ / 1000) * UNLOCK_TIME_MS;
  localparam int unsigned TICK_HZ         = 1000;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / TICK_HZ;
  localparam int unsigned BLINK_TICKS     = 250;
  localparam int unsigned FAST_GAP_TICKS  = 40;
  localparam int unsigned MED_GAP_TICKS   = 120;

  // ----------------------------------------------------------------
  // widths and setpoint steps
  // ----------------------------------------------------------------
  localparam int unsigned SET_W           = 16;
  localparam logic [15:0] SET_MAX         = 16'hEA60;
  localparam logic [15:0] STEP_SLOW       = 16'h0001;
  localparam logic [15:0] STEP_MED        = 16'h000A;
  localparam logic [15:0] STEP_FAST       = 16'h0064;

  // ----------------------------------------------------------------
  // factory and power-on values
  // ----------------------------------------------------------------
  localparam logic [15:0] SET_FACTORY     = 16'h0000;
  localparam logic [4:0]  ADDR_FACTORY    = 5'h01;
  localparam logic [15:0] BAUD_FACTORY    = 16'h4B00;
  localparam logic [15:0] BAUD_MAX        = 16'h9600;
  localparam logic        SRE_RESET       = 1'b0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {BSPC_CH1, BSPC_CH2, BSPC_CH3} bspc_chan_t;
  typedef enum logic [1:0] {BSPC_RNG_10MA, BSPC_RNG_200MA, BSPC_RNG_30MA} bspc_range_t;

endpackage : bspc_pkg
